/* rtl/dcd_chain_decoder.v */
// Daisy-chain command decoder with pass-through switch and cycle classifier
//
// Contract
// - After reset the device sits in pass-through mode, transparent downstream.
// - In pass-through, host control and status lines route to/from downstream port.
// - When selected, control and status lines go to the protocol translator.
// - Classify SPP, EPP, ECP transfers as address write, data write or data read.
// - Up to eight devices per port, three-bit address in command low bits.
// - Command 0000_0aaa makes the current device adopt address aaa.
// - Command 0000_1aaa makes device aaa report its interrupt status.
// - Command 0001_0aaa makes device aaa answer with its product identity.
// - Product-identity request output is driven low during that request.
// - Command 0010_0aaa selects device aaa in EPP style.
// - Command 1101_0aaa selects device aaa in ECP style.
// - Command 1110_0aaa selects device aaa in compatible SPP style.
// - Any command with upper nibble 0011 deselects every device.
// - 0100_0xxx disables chain interrupts, 0100_1xxx enables them.
// - Command 0101_0aaa clears the interrupt latches of device aaa.
// - Command 0101_1aaa sets the interrupt latch of device aaa.
// - Active-on-chain output is high only while this device is selected.
// - Rising edge of peripheral interrupt request sets the interrupt latch.
// - Select-in and initialise both low disables the host status and downstream ports.
// - Supply-sense low tri-states all outputs; drivers enable only when high.
// - Reset held low two clocks restores pass-through and defaults.
// - Address/data strobes follow SPP, EPP and ECP signalling per style.
`timescale 1ns/1ps
`include "dcd_defines.vh"

module dcd_chain_decoder (
	// Clock and reset
	input  wire       SYS_CLK,
	input  wire       RESETN,
	// Command packet input from the packet framer
	input  wire       CMD_VALID,
	input  wire [7:0] CMD_BYTE,
	input  wire       CMD_CURRENT,
	// Host port control lines, active low
	input  wire       HOST_STROBE_N,
	input  wire       HOST_AUTOFEED_N,
	input  wire       HOST_SELECT_IN_N,
	input  wire       HOST_INITIALISE_N,
	// Host port status lines
	output wire       HOST_ACK_N,
	output wire       HOST_BUSY,
	output wire       HOST_PAPER_END,
	output wire       HOST_SELECTED,
	output wire       HOST_ERROR_N,
	output wire       HOST_STATUS_OE,
	// Downstream pass-through port
	output wire       DOWNSTREAM_STROBE_N,
	output wire       DOWNSTREAM_AUTOFEED_N,
	output wire       DOWNSTREAM_SELECT_IN_N,
	output wire       DOWNSTREAM_INITIALISE_N,
	output wire       DOWNSTREAM_OE,
	input  wire       DOWNSTREAM_ACK_N,
	input  wire       DOWNSTREAM_BUSY,
	input  wire       DOWNSTREAM_PAPER_END,
	input  wire       DOWNSTREAM_SELECTED,
	input  wire       DOWNSTREAM_ERROR_N,
	// Translator status, used while selected
	input  wire       XLAT_ACK_N,
	input  wire       XLAT_BUSY,
	input  wire       XLAT_PAPER_END,
	input  wire       XLAT_SELECTED,
	input  wire       XLAT_ERROR_N,
	// Translator side
	output reg  [1:0] XLAT_STYLE,
	output reg  [1:0] XLAT_CYCLE,
	// Peripheral interrupt and supply sense
	input  wire       PERIPH_IRQ,
	input  wire       SUPPLY_SENSE,
	// Chain status outputs
	output wire       ACTIVE_ON_CHAIN_OUT,
	output wire       ACTIVE_ON_CHAIN_OE,
	output wire       PRODUCT_IDENT_REQUEST_N,
	output wire       PRODUCT_IDENT_REQUEST_OE,
	output reg  [2:0] CHAIN_ADDR,
	output reg        INT_REPORT_EN,
	output reg        INT_LATCH,
	output reg        INT_QUERY_REPLY,
	output reg        INT_QUERY_PULSE
);

	// ---------------------------------------------------------------
	// Command decode helpers
	// ---------------------------------------------------------------
	function addr_hit;
		input [7:0] cmd;
		input [2:0] own;
		begin
			addr_hit = (cmd[`DCD_ADDR_MSB:0] == own);
		end
	endfunction

	function [4:0] opcode;
		input [7:0] cmd;
		begin
			opcode = cmd[`DCD_OP_MSB:`DCD_OP_LSB];
		end
	endfunction

	function route_pick;
		input sel;
		input from_xlat;
		input from_down;
		begin
			route_pick = sel ? from_xlat : from_down;
		end
	endfunction

	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	localparam MODE_PASS = 1'b0;
	localparam MODE_SEL  = 1'b1;

	reg        mode;
	reg        next_mode;
	reg [1:0]  next_style;
	reg [2:0]  next_addr;
	reg        next_int_en;
	reg        pid_req;
	reg        next_pid_req;
	reg        irq_prev;
	reg        latch_clr;
	reg        latch_set;
	reg        query;
	reg [1:0]  next_cycle;
	wire [4:0] op;
	wire       hit;
	wire       irq_rise;
	wire       drive_ok;
	wire       ports_ok;
	wire       selected;
	wire       host_illegal;

	assign op       = opcode(CMD_BYTE);
	assign hit      = addr_hit(CMD_BYTE, CHAIN_ADDR);
	assign irq_rise = PERIPH_IRQ & ~irq_prev;

	// ---------------------------------------------------------------
	// Command interpreter
	// ---------------------------------------------------------------
	always @* begin
		next_mode    = mode;
		next_style   = XLAT_STYLE;
		next_addr    = CHAIN_ADDR;
		next_int_en  = INT_REPORT_EN;
		next_pid_req = pid_req;
		latch_clr    = 1'b0;
		latch_set    = 1'b0;
		query        = 1'b0;
		if (CMD_VALID) begin
			// Any command byte except an identity request to this device ends a pending identity request
			next_pid_req = 1'b0;
			if (CMD_BYTE[7:4] == `DCD_NIB_DESEL) begin
				next_mode = MODE_PASS;
			end else begin
				case (op)
					`DCD_OP_ASSIGN: begin
						if (CMD_CURRENT)
							next_addr = CMD_BYTE[`DCD_ADDR_MSB:0];
					end
					`DCD_OP_QINT: begin
						query = hit;
					end
					`DCD_OP_QPID: begin
						next_pid_req = hit;
					end
					`DCD_OP_SEL_EPP: begin
						if (hit) begin
							next_mode  = MODE_SEL;
							next_style = `DCD_STYLE_EPP;
						end
					end
					`DCD_OP_SEL_ECP: begin
						if (hit) begin
							next_mode  = MODE_SEL;
							next_style = `DCD_STYLE_ECP;
						end
					end
					`DCD_OP_SEL_SPP: begin
						if (hit) begin
							next_mode  = MODE_SEL;
							next_style = `DCD_STYLE_SPP;
						end
					end
					`DCD_OP_INT_DIS: begin
						next_int_en = 1'b0;
					end
					`DCD_OP_INT_EN: begin
						next_int_en = 1'b1;
					end
					`DCD_OP_CLR_LATCH: begin
						latch_clr = hit;
					end
					`DCD_OP_SET_LATCH: begin
						latch_set = hit;
					end
					default: begin
						// Unknown codes leave every register alone except the identity request, which clears
						next_mode = mode;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Cycle classifier
	// ---------------------------------------------------------------
	always @* begin
		next_cycle = `DCD_CYC_NONE;
		// Address strobes outrank data strobes in EPP and SPP styles; ECP splits its strobe by autofeed
		if (mode == MODE_SEL) begin
			case (XLAT_STYLE)
				`DCD_STYLE_EPP: begin
					if (!HOST_SELECT_IN_N)
						next_cycle = `DCD_CYC_ADDR_WR;
					else if (!HOST_AUTOFEED_N)
						next_cycle = HOST_STROBE_N ? `DCD_CYC_DATA_RD : `DCD_CYC_DATA_WR;
				end
				`DCD_STYLE_ECP: begin
					if (!HOST_STROBE_N)
						next_cycle = HOST_AUTOFEED_N ? `DCD_CYC_DATA_WR : `DCD_CYC_ADDR_WR;
					else if (!HOST_INITIALISE_N)
						next_cycle = `DCD_CYC_DATA_RD;
				end
				default: begin
					if (!HOST_SELECT_IN_N)
						next_cycle = `DCD_CYC_ADDR_WR;
					else if (!HOST_STROBE_N)
						next_cycle = `DCD_CYC_DATA_WR;
					else if (!HOST_INITIALISE_N)
						next_cycle = `DCD_CYC_DATA_RD;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Chain mode, transfer style and own address
	// ---------------------------------------------------------------
	always @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode       <= MODE_PASS;
			XLAT_STYLE <= `DCD_RST_STYLE;
			CHAIN_ADDR <= `DCD_RST_ADDR;
		end else begin
			mode       <= next_mode;
			XLAT_STYLE <= next_style;
			CHAIN_ADDR <= next_addr;
		end
	end

	// ---------------------------------------------------------------
	// Product identity request
	// ---------------------------------------------------------------
	always @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			pid_req <= 1'b0;
		else
			pid_req <= next_pid_req;
	end

	// ---------------------------------------------------------------
	// Interrupt edge detector
	// ---------------------------------------------------------------
	always @(posedge SYS_CLK or negedge RESETN) begin
		// Idle level of the pulled-up pin, so no false edge follows reset
		if (!RESETN)
			irq_prev <= 1'b1;
		else
			irq_prev <= PERIPH_IRQ;
	end

	// ---------------------------------------------------------------
	// Interrupt latch, report enable and query reply
	// ---------------------------------------------------------------
	always @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN) begin
			INT_REPORT_EN   <= 1'b0;
			INT_LATCH       <= 1'b0;
			INT_QUERY_REPLY <= 1'b0;
			INT_QUERY_PULSE <= 1'b0;
		end else begin
			INT_REPORT_EN   <= next_int_en;
			INT_QUERY_PULSE <= query;
			if (query)
				INT_QUERY_REPLY <= INT_LATCH & INT_REPORT_EN;
			// Set wins over clear so no edge is lost
			if (irq_rise | latch_set)
				INT_LATCH <= 1'b1;
			else if (latch_clr)
				INT_LATCH <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Cycle class register
	// ---------------------------------------------------------------
	always @(posedge SYS_CLK or negedge RESETN) begin
		if (!RESETN)
			XLAT_CYCLE <= `DCD_CYC_NONE;
		else
			XLAT_CYCLE <= next_cycle;
	end

	// ---------------------------------------------------------------
	// Output enables
	// ---------------------------------------------------------------
	// Select-in and initialise both low is the port-off request
	assign host_illegal             = ~HOST_SELECT_IN_N & ~HOST_INITIALISE_N;
	assign drive_ok                 = SUPPLY_SENSE;
	assign ports_ok                 = drive_ok & ~host_illegal;
	assign DOWNSTREAM_OE            = ports_ok;
	assign HOST_STATUS_OE           = ports_ok;
	assign ACTIVE_ON_CHAIN_OE       = drive_ok;
	assign PRODUCT_IDENT_REQUEST_OE = drive_ok;

	// ---------------------------------------------------------------
	// Data switch
	// ---------------------------------------------------------------
	assign selected = (mode == MODE_SEL);

	// Downstream sees idle control while this device is selected
	assign DOWNSTREAM_STROBE_N     = route_pick(selected, 1'b1, HOST_STROBE_N);
	assign DOWNSTREAM_AUTOFEED_N   = route_pick(selected, 1'b1, HOST_AUTOFEED_N);
	assign DOWNSTREAM_SELECT_IN_N  = route_pick(selected, 1'b1, HOST_SELECT_IN_N);
	assign DOWNSTREAM_INITIALISE_N = route_pick(selected, 1'b1, HOST_INITIALISE_N);

	// Host status comes from the translator while selected
	assign HOST_ACK_N     = route_pick(selected, XLAT_ACK_N, DOWNSTREAM_ACK_N);
	assign HOST_BUSY      = route_pick(selected, XLAT_BUSY, DOWNSTREAM_BUSY);
	assign HOST_PAPER_END = route_pick(selected, XLAT_PAPER_END, DOWNSTREAM_PAPER_END);
	assign HOST_SELECTED  = route_pick(selected, XLAT_SELECTED, DOWNSTREAM_SELECTED);
	assign HOST_ERROR_N   = route_pick(selected, XLAT_ERROR_N, DOWNSTREAM_ERROR_N);

	assign ACTIVE_ON_CHAIN_OUT     = selected;
	assign PRODUCT_IDENT_REQUEST_N = ~pid_req;

endmodule // dcd_chain_decoder

/* rtl/dcd_defines.vh */
// Command codes, field positions and timing counts for the chain command decoder
`ifndef DCD_DEFINES_VH
`define DCD_DEFINES_VH

// Command byte fields
`define DCD_ADDR_MSB      2
`define DCD_OP_MSB        7
`define DCD_OP_LSB        3

// Command opcodes (upper five bits) and deselect nibble (upper four bits)
`define DCD_OP_ASSIGN     5'h00
`define DCD_OP_QINT       5'h01
`define DCD_OP_QPID       5'h02
`define DCD_OP_SEL_EPP    5'h04
`define DCD_OP_INT_DIS    5'h08
`define DCD_OP_INT_EN     5'h09
`define DCD_OP_CLR_LATCH  5'h0a
`define DCD_OP_SET_LATCH  5'h0b
`define DCD_OP_SEL_ECP    5'h1a
`define DCD_OP_SEL_SPP    5'h1c
`define DCD_NIB_DESEL     4'h3

// Transfer styles
`define DCD_STYLE_SPP     2'h0
`define DCD_STYLE_EPP     2'h1
`define DCD_STYLE_ECP     2'h2

// Cycle classes
`define DCD_CYC_NONE      2'h0
`define DCD_CYC_ADDR_WR   2'h1
`define DCD_CYC_DATA_WR   2'h2
`define DCD_CYC_DATA_RD   2'h3

// Reset values
`define DCD_RST_ADDR      3'h0
`define DCD_RST_STYLE     2'h0

// Least reset hold, in ns, at a 5 ns clock
`define DCD_RST_HOLD_NS   10
`define DCD_CLK_NS        5
`define DCD_RST_CYCLES    ((`DCD_RST_HOLD_NS + `DCD_CLK_NS - 1) / `DCD_CLK_NS)

`endif

/* verification/dcd_chain_assertions.sv */
// Port assertions for the chain command decoder
`timescale 1ns/1ps
module dcd_chain_assertions (
	// Clock, reset and command
	input wire       SYS_CLK,
	input wire       RESETN,
	input wire       CMD_VALID,
	input wire [7:0] CMD_BYTE,
	input wire       CMD_CURRENT,
	// Host, chain and status
	input wire       HOST_STROBE_N,
	input wire       HOST_SELECT_IN_N,
	input wire       HOST_INITIALISE_N,
	input wire       HOST_STATUS_OE,
	input wire       DOWNSTREAM_STROBE_N,
	input wire       SUPPLY_SENSE,
	input wire       PERIPH_IRQ,
	input wire       ACTIVE_ON_CHAIN_OUT,
	input wire       PRODUCT_IDENT_REQUEST_N,
	input wire [1:0] XLAT_STYLE,
	input wire [2:0] CHAIN_ADDR,
	input wire       INT_LATCH,
	input wire       INT_QUERY_PULSE
);
	default clocking @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);
	wire hit = CMD_BYTE[2:0] == CHAIN_ADDR;
	sequence s_cmd(op);
		CMD_VALID && CMD_BYTE[7:3] == op && hit;
	endsequence
	chk_sel_epp: assert property (
		s_cmd(5'h04) |=> ACTIVE_ON_CHAIN_OUT && XLAT_STYLE == 2'h1) else $error("epp select");
	chk_sel_spp: assert property (
		s_cmd(5'h1c) |=> ACTIVE_ON_CHAIN_OUT && XLAT_STYLE == 2'h0) else $error("spp select");
	chk_sel_ecp: assert property (
		s_cmd(5'h1a) |=> ACTIVE_ON_CHAIN_OUT && XLAT_STYLE == 2'h2) else $error("ecp select");
	chk_deselect_all: assert property (
		CMD_VALID && CMD_BYTE[7:4] == 4'h3 |=> !ACTIVE_ON_CHAIN_OUT) else $error("deselect");
	chk_addr_adopt: assert property (
		CMD_VALID && CMD_BYTE[7:3] == 5'h00 && CMD_CURRENT |=>
		{5'h00, CHAIN_ADDR} == $past(CMD_BYTE)) else $error("address assign");
	chk_ident_low: assert property (
		s_cmd(5'h02) |=> !PRODUCT_IDENT_REQUEST_N) else $error("ident request");
	chk_query_pulse: assert property (
		s_cmd(5'h01) |=> INT_QUERY_PULSE) else $error("query pulse");
	chk_outputs_off: assert property (
		!SUPPLY_SENSE || (!HOST_SELECT_IN_N && !HOST_INITIALISE_N) |-> !HOST_STATUS_OE)
		else $error("output enable");
	chk_pass_route: assert property (
		DOWNSTREAM_STROBE_N == (HOST_STROBE_N | ACTIVE_ON_CHAIN_OUT)) else $error("route");
	chk_irq_latch: assert property (
		$rose(PERIPH_IRQ) |-> ##[1:2] INT_LATCH) else $error("irq latch");
endmodule // dcd_chain_assertions

/* verification/dcd_far_model.sv */
// Far side model: downstream chained device and translator status
`timescale 1ns/1ps
module dcd_far_model (
	// Clock
	input wire       clk,
	// Status towards the decoder
	output reg [4:0] ds,
	output reg [4:0] xl
);
	// Patterns change every cycle so a stale or wrong route shows
	initial ds = 5'h15;
	initial xl = 5'h0a;
	always @(posedge clk) begin
		ds <= ds + 5'h07;
		xl <= xl + 5'h0b;
	end
endmodule // dcd_far_model

/* verification/tb_daisy_chain_command_decoder.sv */
// Self-checking bench for the chain command decoder
`timescale 1ns/1ps
module tb_daisy_chain_command_decoder;
	reg        clk = 0, rst_n = 0, vld = 0, cur = 0, irq = 0, sense = 1;
	reg  [7:0] cmd = 8'h00;
	reg  [3:0] hc = 4'hf;
	reg [31:0] lfsr = 32'h1055f;
	reg  [2:0] a;
	reg  [4:0] op;
	wire [4:0] ds, xl, hs;
	wire [3:0] dc;
	wire [1:0] sty, cyc;
	wire [2:0] addr;
	wire       act, act_oe, pid_n, pid_oe, st_oe, ds_oe, i_en, i_lat, q_rep, q_pls;
	integer    err_count = 0, tests_run = 0, i;
	always #2.5 clk = ~clk;
	dcd_far_model far (.clk(clk), .ds(ds), .xl(xl));
	dcd_chain_decoder dut (.SYS_CLK(clk), .RESETN(rst_n), .CMD_VALID(vld), .CMD_BYTE(cmd),
		.CMD_CURRENT(cur), .HOST_STROBE_N(hc[3]), .HOST_AUTOFEED_N(hc[2]),
		.HOST_SELECT_IN_N(hc[1]), .HOST_INITIALISE_N(hc[0]), .HOST_ACK_N(hs[0]),
		.HOST_BUSY(hs[1]), .HOST_PAPER_END(hs[2]), .HOST_SELECTED(hs[3]), .HOST_ERROR_N(hs[4]),
		.HOST_STATUS_OE(st_oe), .DOWNSTREAM_STROBE_N(dc[3]), .DOWNSTREAM_AUTOFEED_N(dc[2]),
		.DOWNSTREAM_SELECT_IN_N(dc[1]), .DOWNSTREAM_INITIALISE_N(dc[0]), .DOWNSTREAM_OE(ds_oe),
		.DOWNSTREAM_ACK_N(ds[0]), .DOWNSTREAM_BUSY(ds[1]), .DOWNSTREAM_PAPER_END(ds[2]),
		.DOWNSTREAM_SELECTED(ds[3]), .DOWNSTREAM_ERROR_N(ds[4]), .XLAT_ACK_N(xl[0]),
		.XLAT_BUSY(xl[1]), .XLAT_PAPER_END(xl[2]), .XLAT_SELECTED(xl[3]), .XLAT_ERROR_N(xl[4]),
		.XLAT_STYLE(sty), .XLAT_CYCLE(cyc), .PERIPH_IRQ(irq), .SUPPLY_SENSE(sense),
		.ACTIVE_ON_CHAIN_OUT(act), .ACTIVE_ON_CHAIN_OE(act_oe), .PRODUCT_IDENT_REQUEST_N(pid_n),
		.PRODUCT_IDENT_REQUEST_OE(pid_oe), .CHAIN_ADDR(addr), .INT_REPORT_EN(i_en),
		.INT_LATCH(i_lat), .INT_QUERY_REPLY(q_rep), .INT_QUERY_PULSE(q_pls));
	//--------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------
	function [31:0] next_rand(input [31:0] v);
		next_rand = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	task chk(input [8:0] got, input [8:0] exp);
		begin
			tests_run = tests_run + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("unexpected at %0t: got %h want %h", $time, got, exp);
			end
		end
	endtask
	task send(input [7:0] c);
		begin
			@(posedge clk);
			vld <= 1'b1;
			cmd <= c;
			@(posedge clk);
			vld <= 1'b0;
			#1;
		end
	endtask
	task hold(input [3:0] h);
		begin
			@(posedge clk);
			hc <= h;
			@(posedge clk);
			#1;
		end
	endtask
	task stop_test;
		begin
			$display("checks %0d mismatches %0d", tests_run, err_count);
			if (err_count == 0 && tests_run > 0)
				$display("No errors found");
			else
				$display("Errors were found");
			$finish;
		end
	endtask
	//--------------------------------------------------------------
	// Sequence
	//--------------------------------------------------------------
	initial begin
		#60000;
		err_count = err_count + 1;
		stop_test;
	end
	initial begin
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		#1;
		chk({act, pid_n, addr}, 9'h08);
		for (i = 0; i < 20; i = i + 1) begin
			lfsr = next_rand(lfsr);
			hold(lfsr[3:0]);
			chk({dc, hs}, {hc, ds});
			chk(cyc, 2'h0);
		end
		$display("test pass-through done");
		hold(4'hf);
		a = lfsr[6:4] ^ 3'h5;
		@(posedge clk) cur <= 1'b1;
		send({5'h00, a});
		chk(addr, a);
		@(posedge clk) cur <= 1'b0;
		send({5'h04, a + 3'h1});
		chk(act, 1'b0);
		for (i = 0; i < 3; i = i + 1) begin
			op = (i == 0) ? 5'h1c : (i == 1) ? 5'h04 : 5'h1a;
			send({op, a});
			chk({act, sty}, {1'b1, i[1:0]});
			chk({dc, hs}, {4'hf, xl});
			hold((i == 2) ? 4'h3 : 4'hd);
			chk(cyc, 2'h1);
			hold((i == 1) ? 4'h3 : 4'h7);
			chk(cyc, 2'h2);
			hold((i == 1) ? 4'hb : 4'he);
			chk(cyc, 2'h3);
			hold(4'hf);
			send(8'h30);
			chk({act, dc}, 5'h0f);
		end
		$display("test select done");
		send({5'h02, a});
		chk(pid_n, 1'b0);
		send(8'h48);
		chk({pid_n, i_en}, 2'h3);
		@(posedge clk);
		irq <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk(i_lat, 1'b1);
		send({5'h01, a});
		chk({q_rep, q_pls}, 2'h3);
		send({5'h0a, a});
		chk({i_lat, q_pls}, 2'h0);
		send({5'h0b, a});
		chk(i_lat, 1'b1);
		send({5'h0a, a + 3'h1});
		chk(i_lat, 1'b1);
		send(8'h40);
		chk(i_en, 1'b0);
		@(posedge clk) irq <= 1'b0;
		send({5'h0a, a});
		chk(i_lat, 1'b0);
		// Edge and clear fall on one edge: the set must win
		@(posedge clk);
		vld <= 1'b1;
		cmd <= {5'h0a, a};
		irq <= 1'b1;
		@(posedge clk);
		vld <= 1'b0;
		#1;
		chk(i_lat, 1'b1);
		@(posedge clk) irq <= 1'b0;
		$display("test interrupt done");
		hold(4'hc);
		chk({st_oe, ds_oe, act_oe}, 3'h1);
		hold(4'hf);
		@(posedge clk) sense <= 1'b0;
		hold(4'hf);
		chk({st_oe, ds_oe, act_oe, pid_oe}, 4'h0);
		@(posedge clk) sense <= 1'b1;
		send({5'h04, a});
		chk(act, 1'b1);
		@(posedge clk) rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		chk({act, addr, sty}, 6'h00);
		$display("test outputs and reset done");
		stop_test;
	end
endmodule // tb_daisy_chain_command_decoder
bind dcd_chain_decoder dcd_chain_assertions chk_i (.*);
